// ==== sbs_core.sv ====
// Purpose: Command decode, byte-write control and burst sequencing
// Assumes: All synchronous inputs are sampled on core_clk_in
// Notes:   Storage array is kept small; depth is a parameter
//
// What this block does
// (R1) Global and lane write both high: read, all lanes driven, lane enables ignored.
// (R2) Only lane gate low: write exactly lanes whose enables are low.
// (R3) Global write low: write every lane regardless of other controls.
// (R4) Data drivers stay off during every write.
// (R5) Write indication from byte-write decode, true even for no-byte writes.
// (R6) Chip enabled only when high enable is 1 and both low enables 0.
// (R7) Deselect: primary low but not enabled with a strobe low, or primary high with controller strobe.
// (R8) Enabled with processor strobe low: load address, begin read burst.
// (R9) Enabled, processor high, controller low: load address, begin read or write.
// (R10) Strobes high, advance low: step burst address, read or write.
// (R11) Strobes high, advance high: hold address, repeat read or write.
// (R12) Output enable high kills drivers at once; low only allows read drivers.
// (R13) Read with output enable high is a dummy read, counter still advances.
// (R14) Controller holds output enable high long enough before writing data.
// (R15) Non-burst use: processor strobe tied high, controller strobe tied low.
// (R16) Simple burst use: processor strobe and advance tied low-high as documented.
// (R17) Lanes three and four exist only in 32- and 36-bit configurations.
// (R18) Two low address bits preset the two-bit burst counter.
// (R19) Burst order input low selects linear, high selects interleaved.
// (R20) Sleep request high puts the device to sleep, contents retained.
// (R21) Counter wraps in four: linear adds modulo four, interleaved XORs.
// (R22) Synchronous inputs sampled on rising edge; output enable and sleep asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_params.svh"
module sbs_core #(
    parameter int ADDR_W    = `SBS_ADDR_W,
    parameter int LANE_W    = `SBS_LANE_W,
    parameter int LANES     = `SBS_LANES_WIDE,
    parameter int MEM_DEPTH = `SBS_MEM_DEPTH
) (
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      clk_en_in,
    input  wire sbs_pkg::sbs_ctrl_type     ctrl_in,
    input  wire logic [LANES-1:0]          lane_write_enable_n_in,
    input  wire logic [ADDR_W-1:0]         addr_in,
    input  wire logic                      burst_order_select_n_in,
    input  wire logic                      output_enable_n_in,
    input  wire logic                      sleep_request_in,
    input  wire logic [LANES*LANE_W-1:0]   data_in,
    output logic      [LANES*LANE_W-1:0]   data_out,
    output logic      [LANES-1:0]          data_oe_out,
    output sbs_pkg::sbs_op_type            op_out,
    output logic      [ADDR_W-1:0]         cur_addr_out,
    output logic                           sleeping_out
);
    import sbs_pkg::*;

    localparam int CW = `SBS_CNT_W;
    localparam int IW = $clog2(MEM_DEPTH);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic chip_on(input sbs_ctrl_type c);
        chip_on = c.chip_enable_high && !c.primary_chip_enable_n
                  && !c.secondary_chip_enable_n; // R6
    endfunction : chip_on

    function automatic logic [CW-1:0] burst_low(input logic [CW-1:0] start,
                                                input logic [CW-1:0] seq,
                                                input logic          order_n);
        if (order_n)
            burst_low = start ^ seq;          // R19 R21
        else
            burst_low = CW'(start + seq);     // R19 R21
    endfunction : burst_low

    // ------------------------------------------------------------
    // Byte-write decode
    // ------------------------------------------------------------
    logic             write_ind;
    logic [LANES-1:0] lane_wr;

    always_comb begin
        if (!ctrl_in.global_write_n) begin
            lane_wr   = '1;                          // R3
            write_ind = 1'b1;                        // R5
        end else if (!ctrl_in.lane_write_gate_n) begin
            lane_wr   = ~lane_write_enable_n_in;     // R2 R17
            write_ind = 1'b1;                        // R5
        end else begin
            lane_wr   = '0;                          // R1
            write_ind = 1'b0;                        // R5
        end
    end

    // ------------------------------------------------------------
    // Cycle decode and burst sequencing
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] base_r, base_nxt;
    logic [CW-1:0]     seq_r, seq_nxt;
    sbs_op_type        op_r, op_nxt;
    logic              act_r, act_nxt;
    logic [IW-1:0]     idx_nxt;
    logic [ADDR_W-1:0] eff_addr;
    logic              en;
    logic              load;

    assign en = chip_on(ctrl_in);

    always_comb begin
        base_nxt = base_r;
        seq_nxt  = seq_r;
        op_nxt   = op_r;
        act_nxt  = act_r;
        load     = 1'b0;
        if (sleep_request_in) begin
            op_nxt = SBS_OP_SLEEP;                   // R20
        end else if (!ctrl_in.primary_chip_enable_n && !en &&
                     (!ctrl_in.processor_strobe_n || !ctrl_in.controller_strobe_n)) begin
            op_nxt  = SBS_OP_DESELECT;               // R7
            act_nxt = 1'b0;
        end else if (ctrl_in.primary_chip_enable_n && !ctrl_in.controller_strobe_n) begin
            op_nxt  = SBS_OP_DESELECT;               // R7
            act_nxt = 1'b0;
        end else if (en && !ctrl_in.processor_strobe_n) begin
            load    = 1'b1;
            op_nxt  = SBS_OP_READ;                   // R8
        end else if (en && !ctrl_in.controller_strobe_n) begin
            load    = 1'b1;
            op_nxt  = write_ind ? SBS_OP_WRITE : SBS_OP_READ; // R9
        end else if (act_r) begin
            if (!ctrl_in.burst_advance_n)
                seq_nxt = CW'(seq_r + 1'b1);         // R10 R13
            op_nxt = write_ind ? SBS_OP_WRITE : SBS_OP_READ;  // R10 R11
        end else begin
            op_nxt = SBS_OP_IDLE;
        end
        if (load) begin
            base_nxt = addr_in;                      // R18
            seq_nxt  = '0;
            act_nxt  = 1'b1;
        end
    end

    // Address used by the cycle being executed this edge
    always_comb begin
        eff_addr = base_nxt;
        eff_addr[CW-1:0] = burst_low(base_nxt[CW-1:0], seq_nxt,
                                     burst_order_select_n_in); // R18 R21
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_r <= '0;
            seq_r  <= '0;
            op_r   <= SBS_OP_IDLE;
            act_r  <= 1'b0;
        end else if (clk_en_in) begin                // R22
            base_r <= base_nxt;
            seq_r  <= seq_nxt;
            op_r   <= op_nxt;
            act_r  <= act_nxt;
        end
    end

    // ------------------------------------------------------------
    // Storage and read data
    // ------------------------------------------------------------
    logic [LANES*LANE_W-1:0] mem [MEM_DEPTH];
    logic [LANES*LANE_W-1:0] rd_r, rd_nxt;
    logic                    rd_act_r, rd_act_nxt;

    assign idx_nxt = eff_addr[IW-1:0];
    assign rd_nxt  = mem[idx_nxt];
    assign rd_act_nxt = (op_nxt == SBS_OP_READ);

    // One process owns the array; a process per lane would give it LANES drivers
    // Write uses the counter-modified address of this very edge
    always_ff @(posedge core_clk_in) begin
        if (clk_en_in && op_nxt == SBS_OP_WRITE) begin
            for (int j = 0; j < LANES; j++) begin
                if (lane_wr[j])
                    mem[idx_nxt][j*LANE_W +: LANE_W] <= data_in[j*LANE_W +: LANE_W]; // R2 R3
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_r     <= '0;
            rd_act_r <= 1'b0;
        end else if (clk_en_in) begin
            rd_r     <= rd_nxt;
            rd_act_r <= rd_act_nxt;                  // R4
        end
    end

    // Output enable gates drivers without any clock
    assign data_oe_out  = {LANES{rd_act_r && !output_enable_n_in && !sleep_request_in}}; // R1 R12
    assign data_out     = rd_r;
    assign op_out       = op_r;
    assign cur_addr_out = base_r;
    assign sleeping_out = sleep_request_in;          // R20

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_WRITE_NO_DRIVE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R4
        (op_r == SBS_OP_WRITE) |-> (data_oe_out == '0))
        else $error("drivers on during write");
    AST_OE_KILLS: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
        output_enable_n_in |-> (data_oe_out == '0))
        else $error("output enable high but drivers on");
    AST_ALL_LANES_READ: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
        (op_r == SBS_OP_READ && !output_enable_n_in && !sleep_request_in)
        |-> (data_oe_out == '1))
        else $error("read not driving all lanes");
    AST_GLOBAL_ALL: assert property (@(posedge core_clk_in) disable iff (rst_in) // R3
        !ctrl_in.global_write_n |-> (lane_wr == '1 && write_ind))
        else $error("global write misses lanes");
    AST_NO_BYTE_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
        (ctrl_in.global_write_n && !ctrl_in.lane_write_gate_n && lane_write_enable_n_in == '1)
        |-> (write_ind && lane_wr == '0))
        else $error("no-byte write decoded wrongly");
    AST_PSTROBE_READ: assert property (@(posedge core_clk_in) disable iff (rst_in) // R8
        (clk_en_in && !sleep_request_in && en && !ctrl_in.processor_strobe_n)
        |=> (op_r == SBS_OP_READ && base_r == $past(addr_in) && seq_r == '0))
        else $error("processor strobe did not start read");
    AST_DESELECT: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
        (clk_en_in && !sleep_request_in && ctrl_in.primary_chip_enable_n
         && !ctrl_in.controller_strobe_n) |=> (op_r == SBS_OP_DESELECT && !act_r))
        else $error("deselect not taken");
    AST_ADVANCE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10 R13
        (clk_en_in && !sleep_request_in && act_r && ctrl_in.controller_strobe_n
         && ctrl_in.processor_strobe_n && !ctrl_in.burst_advance_n)
        |=> (seq_r == CW'($past(seq_r) + 1'b1)))
        else $error("burst did not advance");
    AST_SUSPEND: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11
        (clk_en_in && !sleep_request_in && act_r && ctrl_in.controller_strobe_n
         && ctrl_in.processor_strobe_n && ctrl_in.burst_advance_n)
        |=> $stable(seq_r) && $stable(base_r))
        else $error("suspended burst moved");

    // ------------------------------------------------------------
    // Checks on byte-write decode
    // ------------------------------------------------------------
    AST_LANE_SELECT: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
        (ctrl_in.global_write_n && !ctrl_in.lane_write_gate_n)
        |-> (write_ind && lane_wr == ~lane_write_enable_n_in))
        else $error("lane write decode wrong");
    AST_READ_NO_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
        (ctrl_in.global_write_n && ctrl_in.lane_write_gate_n)
        |-> (!write_ind && lane_wr == '0))
        else $error("read decoded as write");
    AST_WRITE_OP: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
        (op_nxt == SBS_OP_WRITE) |-> write_ind)
        else $error("write without write indication");

    // ------------------------------------------------------------
    // Checks on cycle decode
    // ------------------------------------------------------------
    AST_CSTROBE_LOAD: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
        (clk_en_in && !sleep_request_in && en && ctrl_in.processor_strobe_n
         && !ctrl_in.controller_strobe_n)
        |=> (base_r == $past(addr_in) && seq_r == '0
             && op_r == ($past(write_ind) ? SBS_OP_WRITE : SBS_OP_READ)))
        else $error("controller strobe did not start burst");
    AST_DESELECT_LOW: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6 R7
        (clk_en_in && !sleep_request_in && !ctrl_in.primary_chip_enable_n && !en
         && (!ctrl_in.processor_strobe_n || !ctrl_in.controller_strobe_n))
        |=> (op_r == SBS_OP_DESELECT && !act_r))
        else $error("partial enable not deselected");
    AST_DESELECT_OFF: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
        (op_r == SBS_OP_DESELECT) |-> (data_oe_out == '0))
        else $error("drivers on after deselect");
    AST_ADVANCE_OP: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
        (clk_en_in && !sleep_request_in && act_r && ctrl_in.controller_strobe_n
         && ctrl_in.processor_strobe_n && !ctrl_in.burst_advance_n)
        |=> (op_r == ($past(write_ind) ? SBS_OP_WRITE : SBS_OP_READ)))
        else $error("continued burst wrong direction");
    AST_SUSPEND_OP: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11
        (clk_en_in && !sleep_request_in && act_r && ctrl_in.controller_strobe_n
         && ctrl_in.processor_strobe_n && ctrl_in.burst_advance_n)
        |=> (op_r == ($past(write_ind) ? SBS_OP_WRITE : SBS_OP_READ)))
        else $error("suspended burst wrong direction");
    // Sleep must not lose the burst, so the next wake resumes cleanly
    AST_SLEEP_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in) // R20
        (clk_en_in && sleep_request_in)
        |=> (op_r == SBS_OP_SLEEP && $stable(base_r) && $stable(seq_r) && $stable(act_r)))
        else $error("sleep disturbed burst state");
    AST_SLEEP_DARK: assert property (@(posedge core_clk_in) disable iff (rst_in) // R20
        sleep_request_in |-> (sleeping_out && data_oe_out == '0))
        else $error("drivers on while asleep");

    // ------------------------------------------------------------
    // Checks on burst address
    // ------------------------------------------------------------
    AST_INTERLEAVE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R19 R21
        burst_order_select_n_in |-> ((eff_addr[CW-1:0] ^ base_nxt[CW-1:0]) == seq_nxt))
        else $error("interleaved order wrong");
    AST_LINEAR: assert property (@(posedge core_clk_in) disable iff (rst_in) // R19 R21
        !burst_order_select_n_in |-> (CW'(eff_addr[CW-1:0] - base_nxt[CW-1:0]) == seq_nxt))
        else $error("linear order wrong");
    AST_UPPER_ADDR: assert property (@(posedge core_clk_in) disable iff (rst_in) // R18
        eff_addr[ADDR_W-1:CW] == base_nxt[ADDR_W-1:CW])
        else $error("burst touched upper address");
endmodule : sbs_core
`default_nettype wire

// ==== sbs_host_model.sv ====
// Purpose: Bus master model for the burst SRAM command pins
// Assumes: Every pin changes just after a rising edge, except oe when set_oe changes it between edges
// Notes:   Data lines toggle on cycles that carry no write data
`timescale 1ns/100ps
`default_nettype none
module sbs_host_model (
    input  wire logic              clk_in,
    output sbs_pkg::sbs_ctrl_type  ctrl_out,
    output logic [3:0]             lane_n_out,
    output logic [18:0]            addr_out,
    output logic [35:0]            wdata_out,
    output logic                   oe_n_out
);
    import sbs_pkg::*;
    initial begin
        ctrl_out   = 8'hb7;
        lane_n_out = 4'hf;
        addr_out   = 19'h0_0000;
        wdata_out  = 36'h0_0000_0000;
        oe_n_out   = 1'b0;
    end
    // ----------------------------------------------------------------
    // One bus cycle; oe is driven at the same edge as the other pins, from the caller's argument
    // ----------------------------------------------------------------
    task automatic cycle(input sbs_ctrl_type c, input logic [3:0] ln,
                         input logic [18:0] a, input logic [35:0] d, input logic oe_n);
        @(posedge clk_in);
        ctrl_out   <= c;
        lane_n_out <= ln;
        addr_out   <= a;
        wdata_out  <= (c.global_write_n && c.lane_write_gate_n) ? ~wdata_out : d;
        oe_n_out   <= oe_n;
    endtask : cycle
    // Asynchronous output enable change between edges
    task automatic set_oe(input logic v);
        oe_n_out = v;
    endtask : set_oe
endmodule : sbs_host_model
`default_nettype wire

// ==== sbs_params.svh ====
// Purpose: Constants for the sync burst SRAM command logic
// Assumes: Included by the package and the design module
// Notes:   Widths, depth and burst figures only; no timing counts needed
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_ADDR_W        19
`define SBS_LANE_W        9
`define SBS_LANES_WIDE    4
`define SBS_LANES_NARROW  2
`define SBS_CNT_W         2
`define SBS_BURST_LEN     4
`define SBS_MEM_DEPTH     256
`endif

// ==== sbs_pkg.sv ====
// Purpose: Types for the sync burst SRAM command logic
// Assumes: sbs_params.svh holds the numeric constants
// Notes:   Control pins travel as one packed struct
`include "sbs_params.svh"
package sbs_pkg;
    typedef struct packed {
        logic primary_chip_enable_n;
        logic chip_enable_high;
        logic secondary_chip_enable_n;
        logic processor_strobe_n;
        logic controller_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic lane_write_gate_n;
    } sbs_ctrl_type;

    typedef enum logic [4:0] {
        SBS_OP_IDLE     = 5'b0_0001,
        SBS_OP_DESELECT = 5'b0_0010,
        SBS_OP_READ     = 5'b0_0100,
        SBS_OP_WRITE    = 5'b0_1000,
        SBS_OP_SLEEP    = 5'b1_0000
    } sbs_op_type;
endpackage : sbs_pkg

// ==== sync_burst_sram_command_logic_tb_top.sv ====
// Purpose: Self-checking bench for the burst SRAM command logic
// Assumes: Reference memory mirrors the low 8 address bits
// Notes:   Each command but the last is checked just after the edge that samples it
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_command_logic_tb_top;
    import sbs_pkg::*;
    localparam logic [7:0] IDL = 8'hb7, PRD = 8'h4f, CWG = 8'h55, CWB = 8'h56;
    localparam logic [7:0] NRD = 8'hbb, NWR = 8'hb9, SRD = 8'hbf, DS1 = 8'h0f;
    logic         core_clk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic         bo_n = 1'b0;
    logic         sleep = 1'b0;
    sbs_ctrl_type ctrl;
    logic [3:0]   ln, doe, l;
    logic [18:0]  addr, ca;
    logic [35:0]  wd, rd, p_dat;
    logic         oe_n, slp, p_rd = 1'b0;
    sbs_op_type   op, p_op = SBS_OP_DESELECT;
    logic [35:0]  ref_mem [256];
    logic [7:0]   a;
    int           mismatches = 0, tests_run = 0, cycles = 0, i, k, s;
    always #25 core_clk_in = ~core_clk_in;
    sbs_host_model sbs_host_model_inst (.clk_in(core_clk_in), .ctrl_out(ctrl),
        .lane_n_out(ln), .addr_out(addr), .wdata_out(wd), .oe_n_out(oe_n));
    sbs_core sbs_core_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .ctrl_in(ctrl), .lane_write_enable_n_in(ln), .addr_in(addr),
        .burst_order_select_n_in(bo_n), .output_enable_n_in(oe_n),
        .sleep_request_in(sleep), .data_in(wd), .data_out(rd), .data_oe_out(doe),
        .op_out(op), .cur_addr_out(ca), .sleeping_out(slp));
    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] eff(input logic [7:0] b, input logic [1:0] q);
        return {b[7:2], bo_n ? (b[1:0] ^ q) : (b[1:0] + q)};
    endfunction : eff
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic chk_op(input sbs_op_type g, input sbs_op_type e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_op
    task automatic final_report;
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Drive one command, then judge the one sampled at this edge
    task automatic issue(input logic [7:0] c, input logic [3:0] lw, input logic [7:0] b,
        input logic [1:0] q, input logic oe, input logic [3:0] wm, input sbs_op_type eo);
        logic [7:0]  ea;
        logic [35:0] d;
        ea = eff(b, q);
        d = 36'({$urandom, $urandom});
        sbs_host_model_inst.cycle(c, lw, {11'h000, b}, d, oe);
        #1;
        chk_op(op, p_op);
        chk(36'(doe), (p_rd && !oe) ? 36'h0_0000_000f : 36'h0_0000_0000);
        if (p_rd && !oe) begin
            chk(rd, p_dat);
        end
        for (int g = 0; g < 4; g++) begin
            if (eo == SBS_OP_WRITE && wm[g]) begin
                ref_mem[ea][g*9 +: 9] = d[g*9 +: 9];
            end
        end
        p_op = eo;
        p_rd = (eo == SBS_OP_READ);
        p_dat = ref_mem[ea];
    endtask : issue
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h0000_ad67));
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        for (k = 0; k < 256; k++) begin
            issue(CWG, 4'($urandom), 8'(k), 2'd0, 1'b0, 4'hf, SBS_OP_WRITE);
        end
        for (i = 0; i < 12; i++) begin
            bo_n <= i[0];
            a = 8'($urandom);
            l = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom);
            issue(CWB, l, a, 2'd0, 1'b0, ~l, SBS_OP_WRITE);
            for (s = 1; s < 4; s++) begin
                issue(NWR, 4'($urandom), a, 2'(s), 1'b0, 4'hf, SBS_OP_WRITE);
            end
            issue(PRD, 4'($urandom), a, 2'd0, 1'b0, 4'h0, SBS_OP_READ);
            for (s = 1; s < 4; s++) begin
                issue(NRD, 4'($urandom), a, 2'(s), 1'b0, 4'h0, SBS_OP_READ);
            end
            issue(SRD, 4'($urandom), a, 2'd3, 1'b0, 4'h0, SBS_OP_READ);
            chk(36'(ca), 36'({11'h000, a}));
            issue(i[0] ? DS1 : IDL, 4'hf, a, 2'd0, 1'b0, 4'h0, SBS_OP_DESELECT);
        end
        issue(8'h57, 4'h0, a, 2'd0, 1'b0, 4'h0, SBS_OP_READ);
        issue(SRD, 4'h0, a, 2'd0, 1'b0, 4'h0, SBS_OP_READ);
        sbs_host_model_inst.set_oe(1'b1);
        #1;
        chk(36'(doe), 36'h0_0000_0000);
        issue(PRD, 4'h0, a, 2'd0, 1'b1, 4'h0, SBS_OP_READ);
        issue(NRD, 4'h0, a, 2'd1, 1'b1, 4'h0, SBS_OP_READ);
        issue(NRD, 4'h0, a, 2'd2, 1'b0, 4'h0, SBS_OP_READ);
        issue(CWG, 4'h0, a ^ 8'h55, 2'd0, 1'b1, 4'hf, SBS_OP_WRITE);
        issue(PRD, 4'h0, a, 2'd0, 1'b0, 4'h0, SBS_OP_SLEEP);
        sleep <= 1'b1;
        #1;
        chk(36'(slp), 36'h0_0000_0001);
        issue(IDL, 4'hf, a, 2'd0, 1'b0, 4'h0, SBS_OP_DESELECT);
        sleep <= 1'b0;
        issue(IDL, 4'hf, a, 2'd0, 1'b0, 4'h0, SBS_OP_DESELECT);
        issue(IDL, 4'hf, a, 2'd0, 1'b0, 4'h0, SBS_OP_DESELECT);
        final_report();
    end
endmodule : sync_burst_sram_command_logic_tb_top
`default_nettype wire
